// file: ftd_top.sv
// Operation
// - Detect pin driven only when enable bit set
// - Override bit replaces comparator result on pin
// - Overridden pin takes the forced-value bit
// - Compare magnitude with 13-bit upper threshold
// - Compare magnitude with 13-bit lower threshold
// - Pin clears after dwell count below lower
// - Dwell load from low and high bytes
// - Sync style bit: zero means continuous
// - Next-edge mode syncs once, clears enable
// - No sync while sync enable is zero
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`include "ftd_map.svh"
module ftd_top (
	input wire logic clk, // System clock, 20 MHz
	input wire logic rstn, // Async reset, active low
	input wire ftd_pkg::ftd_addr_t reg_addr, // Register address
	input wire ftd_pkg::ftd_byte_t reg_wdata, // Register write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output ftd_pkg::ftd_byte_t reg_rdata, // Read data, cycle after read
	input wire ftd_pkg::ftd_mag_t sample_mag, // Fine sample magnitude
	input wire logic sysref_pin, // Reference pulse pin, asynchronous
	output logic threshold_flag_pin, // Over-range detect pin
	output logic monitor_sync_pulse, // Signal monitor alignment pulse
	output logic irq // Interrupt, level
);
	import ftd_pkg::*;

	ftd_byte_t ctrl_q, ctrl_d; // Detect control
	ftd_byte_t up_lo_q, up_lo_d; // Upper threshold low byte
	ftd_byte_t up_hi_q, up_hi_d; // Upper threshold high bits
	ftd_byte_t lo_lo_q, lo_lo_d; // Lower threshold low byte
	ftd_byte_t lo_hi_q, lo_hi_d; // Lower threshold high bits
	ftd_byte_t dw_lo_q, dw_lo_d; // Dwell low byte
	ftd_byte_t dw_hi_q, dw_hi_d; // Dwell high byte
	ftd_byte_t sync_q, sync_d; // Sync control
	ftd_byte_t stat_q, stat_d; // Sticky event status
	ftd_byte_t mask_q, mask_d; // Interrupt mask
	ftd_byte_t rdata_q, rdata_d; // Read data register
	logic flag_q, flag_d; // Comparator flag state
	logic pin_q, pin_d; // Detect pin register
	logic msync_q, msync_d; // Alignment pulse register
	logic irq_q, irq_d; // Interrupt register
	logic ref_s1_q, ref_s2_q, ref_s3_q; // Reference synchroniser and edge stage
	ftd_mag_t upper_thr; // Assembled upper threshold
	ftd_mag_t lower_thr; // Assembled lower threshold
	logic above_upper; // Magnitude over upper threshold
	logic ref_edge; // Rising reference edge
	logic sync_hit; // Synchronisation takes place
	ftd_byte_t ev; // Events of this cycle
	logic wr_sync; // Software write to sync control

	ftd_dwell_if dwi ();

	// Threshold assembly and comparison
	assign upper_thr = {up_hi_q[4:0], up_lo_q};
	assign lower_thr = {lo_hi_q[4:0], lo_lo_q};
	assign above_upper = sample_mag > upper_thr;
	assign dwi.below = sample_mag < lower_thr;
	assign dwi.armed = flag_q;
	assign dwi.load = {dw_hi_q, dw_lo_q};

	// Dwell counter
	ftd_dwell u_dwell (
		.clk (clk),
		.rstn (rstn),
		.dw (dwi)
	);

	// Reference pin synchroniser and edge stage
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ref_s1_q <= 1'b0;
			ref_s2_q <= 1'b0;
			ref_s3_q <= 1'b0;
		end else begin
			ref_s1_q <= sysref_pin;
			ref_s2_q <= ref_s1_q;
			ref_s3_q <= ref_s2_q;
		end
	end

	// Rising edge taken only from synchronised stages
	assign ref_edge = ref_s2_q && !ref_s3_q;
	// Armed sync acts on each edge; source keeps period multiple of monitor period
	assign sync_hit = sync_q[`FTD_SYNC_EN] && ref_edge;
	assign wr_sync = reg_wr && (reg_addr == `FTD_OFS_SYNC);

	// Detect flag and pin next state
	always_comb begin
		flag_d = flag_q;
		if (!ctrl_q[`FTD_CTRL_EN]) begin
			flag_d = 1'b0;
		end else if (above_upper) begin
			flag_d = 1'b1;
		end else if (dwi.expired) begin
			flag_d = 1'b0;
		end
		if (!ctrl_q[`FTD_CTRL_EN]) begin
			pin_d = 1'b0;
		end else if (ctrl_q[`FTD_CTRL_OVR]) begin
			pin_d = ctrl_q[`FTD_CTRL_FVAL];
		end else begin
			pin_d = flag_q;
		end
		msync_d = sync_hit;
	end

	// Event collection and interrupt
	always_comb begin
		ev = 8'h00;
		ev[`FTD_EV_RISE] = flag_d && !flag_q;
		ev[`FTD_EV_FALL] = !flag_d && flag_q;
		ev[`FTD_EV_SYNC] = sync_hit;
		irq_d = |(stat_q & mask_q);
	end

	// Register file next state
	always_comb begin
		ctrl_d = ctrl_q;
		up_lo_d = up_lo_q;
		up_hi_d = up_hi_q;
		lo_lo_d = lo_lo_q;
		lo_hi_d = lo_hi_q;
		dw_lo_d = dw_lo_q;
		dw_hi_d = dw_hi_q;
		sync_d = sync_q;
		mask_d = mask_q;
		stat_d = stat_q;
		rdata_d = 8'h00;
		// Next-edge mode drops its own enable after one alignment
		if (sync_hit && sync_q[`FTD_SYNC_NEXT]) begin
			sync_d[`FTD_SYNC_EN] = 1'b0;
		end
		if (reg_wr) begin
			case (reg_addr)
				`FTD_OFS_CTRL: ctrl_d = reg_wdata & `FTD_CTRL_MASK;
				`FTD_OFS_UP_LO: up_lo_d = reg_wdata;
				`FTD_OFS_UP_HI: up_hi_d = reg_wdata & `FTD_THR_HI_MASK;
				`FTD_OFS_LO_LO: lo_lo_d = reg_wdata;
				`FTD_OFS_LO_HI: lo_hi_d = reg_wdata & `FTD_THR_HI_MASK;
				`FTD_OFS_DW_LO: dw_lo_d = reg_wdata;
				`FTD_OFS_DW_HI: dw_hi_d = reg_wdata;
				`FTD_OFS_SYNC: sync_d = reg_wdata & `FTD_SYNC_MASK;
				`FTD_OFS_IRQ_STAT: stat_d = stat_q & ~reg_wdata;
				`FTD_OFS_IRQ_MASK: mask_d = reg_wdata & `FTD_EV_MASK;
				default: begin
					// Unmapped write ignored
				end
			endcase
		end
		// New events win over a clear in the same cycle
		stat_d = stat_d | ev;
		if (reg_rd) begin
			case (reg_addr)
				`FTD_OFS_CTRL: rdata_d = ctrl_q;
				`FTD_OFS_UP_LO: rdata_d = up_lo_q;
				`FTD_OFS_UP_HI: rdata_d = up_hi_q;
				`FTD_OFS_LO_LO: rdata_d = lo_lo_q;
				`FTD_OFS_LO_HI: rdata_d = lo_hi_q;
				`FTD_OFS_DW_LO: rdata_d = dw_lo_q;
				`FTD_OFS_DW_HI: rdata_d = dw_hi_q;
				`FTD_OFS_SYNC: rdata_d = sync_q;
				`FTD_OFS_IRQ_STAT: rdata_d = stat_q;
				`FTD_OFS_IRQ_MASK: rdata_d = mask_q;
				default: rdata_d = 8'h00;
			endcase
		end
	end

	// State registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_q <= `FTD_RST_BYTE;
			up_lo_q <= `FTD_RST_BYTE;
			up_hi_q <= `FTD_RST_BYTE;
			lo_lo_q <= `FTD_RST_BYTE;
			lo_hi_q <= `FTD_RST_BYTE;
			dw_lo_q <= `FTD_RST_BYTE;
			dw_hi_q <= `FTD_RST_BYTE;
			sync_q <= `FTD_RST_BYTE;
			stat_q <= `FTD_RST_BYTE;
			mask_q <= `FTD_RST_BYTE;
			rdata_q <= `FTD_RST_BYTE;
			flag_q <= 1'b0;
			pin_q <= 1'b0;
			msync_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			up_lo_q <= up_lo_d;
			up_hi_q <= up_hi_d;
			lo_lo_q <= lo_lo_d;
			lo_hi_q <= lo_hi_d;
			dw_lo_q <= dw_lo_d;
			dw_hi_q <= dw_hi_d;
			sync_q <= sync_d;
			stat_q <= stat_d;
			mask_q <= mask_d;
			rdata_q <= rdata_d;
			flag_q <= flag_d;
			pin_q <= pin_d;
			msync_q <= msync_d;
			irq_q <= irq_d;
		end
	end

	// Outputs straight from flip-flops
	assign reg_rdata = rdata_q;
	assign threshold_flag_pin = pin_q;
	assign monitor_sync_pulse = msync_q;
	assign irq = irq_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	// Armed next-edge mode meets a reference edge without a software write
	sequence s_next_hit;
		sync_q[`FTD_SYNC_EN] && sync_q[`FTD_SYNC_NEXT] && ref_edge && !wr_sync;
	endsequence

	// Dwell elapsed with the flag set and nothing above the upper threshold
	sequence s_dwell_done;
		ctrl_q[`FTD_CTRL_EN] && flag_q && dwi.expired && !above_upper;
	endsequence

	// Flag low first, pin low one cycle later unless the pin is forced
	sequence s_flag_gone;
		!flag_q ##1 (!threshold_flag_pin || $past(ctrl_q[`FTD_CTRL_OVR]));
	endsequence

	a_pin_disabled: assert property (!ctrl_q[`FTD_CTRL_EN] |=> !threshold_flag_pin)
		else $error("detect pin high while disabled");
	a_force_level: assert property ((ctrl_q[`FTD_CTRL_EN] && ctrl_q[`FTD_CTRL_OVR])
		|=> threshold_flag_pin == $past(ctrl_q[`FTD_CTRL_FVAL]))
		else $error("forced pin level wrong");
	a_normal_pin: assert property ((ctrl_q[`FTD_CTRL_EN] && !ctrl_q[`FTD_CTRL_OVR])
		|=> threshold_flag_pin == $past(flag_q))
		else $error("pin not following comparator");
	a_upper_set: assert property ((ctrl_q[`FTD_CTRL_EN] && sample_mag > upper_thr)
		|=> flag_q ##1 (threshold_flag_pin || $past(ctrl_q[`FTD_CTRL_OVR]) || !$past(ctrl_q[`FTD_CTRL_EN])))
		else $error("flag not set above upper threshold");
	a_hold_above_low: assert property ((ctrl_q[`FTD_CTRL_EN] && flag_q && sample_mag >= lower_thr)
		|=> flag_q)
		else $error("flag dropped while not below lower threshold");
	a_dwell_bytes: assert property ((reg_wr && reg_addr == `FTD_OFS_DW_HI)
		|=> dwi.load[15:8] == $past(reg_wdata))
		else $error("dwell high byte not loaded");
	a_sync_idle: assert property (!sync_q[`FTD_SYNC_EN] |=> !monitor_sync_pulse)
		else $error("sync pulse while sync disabled");
	a_next_clear: assert property (s_next_hit |=> !sync_q[`FTD_SYNC_EN] && monitor_sync_pulse ##1 !monitor_sync_pulse)
		else $error("next-edge sync did not clear enable");
	a_cont_keep: assert property ((sync_q[`FTD_SYNC_EN] && !sync_q[`FTD_SYNC_NEXT] && ref_edge && !wr_sync)
		|=> sync_q[`FTD_SYNC_EN] && monitor_sync_pulse)
		else $error("continuous sync lost its enable");
	a_irq_level: assert property (|(stat_q & mask_q) |=> irq)
		else $error("interrupt not raised");

	// Interrupt drops once no unmasked status bit remains
	a_irq_quiet: assert property (!(|(stat_q & mask_q)) |=> !irq)
		else $error("interrupt raised with nothing pending");

	// Read data only in the cycle after a read strobe
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside read cycle");

	// Status bits stay set until software writes a one to them
	a_stat_sticky: assert property (!(reg_wr && reg_addr == `FTD_OFS_IRQ_STAT)
		|=> (stat_q & $past(stat_q)) == $past(stat_q))
		else $error("status bit lost without a clear");

	// A flag rise is recorded even against a clear in the same cycle
	a_rise_event: assert property ((flag_d && !flag_q) |=> stat_q[`FTD_EV_RISE])
		else $error("flag rise not recorded");

	// Each alignment is recorded and pulsed one cycle later
	a_sync_event: assert property (sync_hit |=> stat_q[`FTD_EV_SYNC] && monitor_sync_pulse)
		else $error("alignment not recorded");

	// An alignment pulse always follows an armed reference edge
	a_pulse_source: assert property (monitor_sync_pulse |-> $past(sync_hit))
		else $error("alignment pulse without armed edge");

	// Reserved control and sync bits always hold zero
	a_reserved_zero: assert property (((ctrl_q & ~`FTD_CTRL_MASK) == 8'h00)
		&& ((sync_q & ~`FTD_SYNC_MASK) == 8'h00))
		else $error("reserved bit set");

	// Threshold high registers keep only their five value bits
	a_thr_fields: assert property (up_hi_q[7:5] == 3'h0 && lo_hi_q[7:5] == 3'h0)
		else $error("threshold reserved bits set");

	// Dwell low byte lands in the load value
	a_dwell_low_byte: assert property ((reg_wr && reg_addr == `FTD_OFS_DW_LO)
		|=> dwi.load[7:0] == $past(reg_wdata))
		else $error("dwell low byte not loaded");

	// Disabled detection keeps the flag cleared
	a_flag_disabled: assert property (!ctrl_q[`FTD_CTRL_EN] |=> !flag_q)
		else $error("flag set while disabled");

	// Release after the dwell: flag drops, then the pin follows
	a_dwell_release: assert property (s_dwell_done |=> s_flag_gone)
		else $error("flag held after dwell elapsed");
endmodule

// file: ftd_map.svh
`ifndef FTD_MAP_SVH
`define FTD_MAP_SVH

// Register offsets
`define FTD_OFS_CTRL 12'h245
`define FTD_OFS_UP_LO 12'h247
`define FTD_OFS_UP_HI 12'h248
`define FTD_OFS_LO_LO 12'h249
`define FTD_OFS_LO_HI 12'h24A
`define FTD_OFS_DW_LO 12'h24B
`define FTD_OFS_DW_HI 12'h24C
`define FTD_OFS_SYNC 12'h26F
`define FTD_OFS_IRQ_STAT 12'h280
`define FTD_OFS_IRQ_MASK 12'h281

// Control register fields
`define FTD_CTRL_EN 0
`define FTD_CTRL_FVAL 2
`define FTD_CTRL_OVR 3
`define FTD_CTRL_MASK 8'h0D

// Threshold high byte field width mask
`define FTD_THR_HI_MASK 8'h1F

// Sync control fields
`define FTD_SYNC_EN 0
`define FTD_SYNC_NEXT 1
`define FTD_SYNC_MASK 8'h03

// Interrupt status bits
`define FTD_EV_RISE 0
`define FTD_EV_FALL 1
`define FTD_EV_SYNC 2
`define FTD_EV_MASK 8'h07

// Reset values
`define FTD_RST_BYTE 8'h00
`define FTD_RST_DWELL 16'h0000

`endif

// file: ftd_pkg.sv
package ftd_pkg;
	// Register bus address
	typedef logic [11:0] ftd_addr_t;
	// Register bus data byte
	typedef logic [7:0] ftd_byte_t;
	// Threshold and magnitude value
	typedef logic [12:0] ftd_mag_t;
	// Dwell counter value
	typedef logic [15:0] ftd_dwell_t;
endpackage

// file: ftd_dwell_if.sv
`timescale 1ns/1ps
interface ftd_dwell_if;
	import ftd_pkg::*;
	logic below; // Magnitude under the lower threshold
	logic armed; // Flag is set, dwell is running
	ftd_dwell_t load; // Dwell load value
	logic expired; // Dwell elapsed, flag may drop
	modport ctrl (output below, output armed, output load, input expired);
	modport dwell (input below, input armed, input load, output expired);
endinterface

// file: ftd_dwell.sv
`timescale 1ns/1ps
`include "ftd_map.svh"
module ftd_dwell (
	input wire logic clk, // System clock
	input wire logic rstn, // Async reset, active low
	ftd_dwell_if.dwell dw // Dwell control group
);
	import ftd_pkg::*;

	ftd_dwell_t cnt_q; // Remaining dwell cycles
	ftd_dwell_t cnt_d; // Next dwell count

	// Reload while idle or at or above the lower threshold, count down while below
	always_comb begin
		cnt_d = cnt_q;
		if (!dw.armed || !dw.below) begin
			cnt_d = dw.load;
		end else if (cnt_q != 16'h0000) begin
			cnt_d = cnt_q - 16'h0001;
		end
	end

	// Counter register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= `FTD_RST_DWELL;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// Elapsed once the count has run out with the sample still low
	assign dw.expired = dw.armed && dw.below && (cnt_q == 16'h0000);

	a_dwell_reload: assert property (@(posedge clk) disable iff (!rstn)
		(dw.armed && !dw.below) |=> (cnt_q == $past(dw.load)))
		else $error("dwell count not reloaded above lower threshold");
	a_dwell_below: assert property (@(posedge clk) disable iff (!rstn)
		dw.expired |-> (dw.below && $past(dw.below)) || ($past(dw.load) == 16'h0000))
		else $error("dwell expired without staying below threshold");
endmodule

// file: ftd_agc_model.sv
`timescale 1ns/1ps
// Gain control stand-in: watches the detect pin and counts each over-range alert
module ftd_agc_model (
	input wire logic clk, // System clock
	input wire logic rstn, // Async reset, active low
	input wire logic threshold_flag_pin, // Detect pin from the block
	output logic [7:0] rise_cnt_q // Alerts seen so far
);
	logic pin_q; // Last sampled pin level
	logic [7:0] rise_cnt_d; // Next alert count
	// An alert is a low-to-high change of the pin
	always_comb begin
		rise_cnt_d = rise_cnt_q + {7'h00, threshold_flag_pin & ~pin_q};
	end
	// Register pin level and count
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pin_q <= 1'b0;
			rise_cnt_q <= 8'h00;
		end else begin
			pin_q <= threshold_flag_pin;
			rise_cnt_q <= rise_cnt_d;
		end
	end
endmodule

// file: tb.sv
`timescale 1ns/1ps
module tb;
	import ftd_pkg::*;
	logic clk = 1'b0; // System clock
	logic rstn = 1'b0; // Reset, active low
	ftd_addr_t reg_addr = 12'h000; // Register address
	ftd_byte_t reg_wdata = 8'h00; // Write data
	logic reg_wr = 1'b0; // Write strobe
	logic reg_rd = 1'b0; // Read strobe
	ftd_byte_t reg_rdata; // Read data
	ftd_mag_t sample_mag = 13'h0000; // Magnitude stimulus
	logic sysref_pin = 1'b0; // Reference pulse stimulus
	logic pin; // Detect pin
	logic sync_pulse; // Alignment pulse
	logic irq; // Interrupt
	logic [7:0] rises; // Alerts seen by the gain control model
	logic [7:0] r0; // Alert count at scenario start
	int error_cnt = 0; // Mismatches
	int checked = 0; // Comparisons
	int sync_cnt = 0; // Alignment pulses seen
	ftd_addr_t regs [9] = '{12'h245, 12'h247, 12'h248, 12'h249, 12'h24A, 12'h24B, 12'h24C, 12'h26F, 12'h281};
	ftd_byte_t wmask [9] = '{8'h0D, 8'hFF, 8'h1F, 8'hFF, 8'h1F, 8'hFF, 8'hFF, 8'h03, 8'h07};
	// Clock, 50 ns period
	always #25 clk = ~clk;
	ftd_top i_ftd_top (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_mag(sample_mag), .sysref_pin(sysref_pin),
		.threshold_flag_pin(pin), .monitor_sync_pulse(sync_pulse), .irq(irq));
	ftd_agc_model i_ftd_agc_model (.clk(clk), .rstn(rstn), .threshold_flag_pin(pin), .rise_cnt_q(rises));
	// Count alignment pulses
	always @(posedge clk) begin
		if (sync_pulse === 1'b1) sync_cnt <= sync_cnt + 1;
	end
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checked++;
		if (s !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	// Wait n edges, then let their updates settle
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input ftd_addr_t a, input ftd_byte_t d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input ftd_addr_t a, input ftd_byte_t e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk("rdata", reg_rdata, e);
	endtask
	task automatic mag(input ftd_mag_t v);
		@(posedge clk);
		sample_mag <= v;
	endtask
	// Reference pulses keep a fixed spacing in clocks
	task automatic ref_pulse;
		@(posedge clk);
		sysref_pin <= 1'b1;
		cyc(2);
		@(posedge clk);
		sysref_pin <= 1'b0;
		cyc(8);
	endtask
	task automatic summarize;
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Watchdog
	initial begin
		#500000;
		error_cnt++;
		summarize();
	end
	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		foreach (regs[i]) rd(regs[i], 8'h00);
		rd(12'h280, 8'h00);
		foreach (regs[i]) begin
			wr(regs[i], 8'hFF);
			rd(regs[i], wmask[i]);
			wr(regs[i], 8'h00);
		end
		rd(12'h300, 8'h00);
		// Upper 0x100, lower 0x080, dwell 3
		wr(12'h247, 8'h00);
		wr(12'h248, 8'h01);
		wr(12'h249, 8'h80);
		wr(12'h24B, 8'h03);
		wr(12'h280, 8'h07);
		wr(12'h281, 8'h03);
		wr(12'h245, 8'h01);
		r0 = rises;
		mag(13'h0101);
		cyc(1);
		chk("pin", pin, 1'b0);
		cyc(1);
		chk("pin", pin, 1'b1);
		mag(13'h007F);
		cyc(4);
		chk("pin", pin, 1'b1);
		cyc(1);
		chk("pin", pin, 1'b0);
		// Equal to lower threshold restarts the dwell
		mag(13'h0101);
		cyc(3);
		mag(13'h007F);
		cyc(2);
		mag(13'h0080);
		mag(13'h007F);
		cyc(1);
		chk("pin", pin, 1'b1);
		cyc(3);
		chk("pin", pin, 1'b1);
		cyc(1);
		chk("pin", pin, 1'b0);
		chk("alerts", 16'(rises - r0), 16'h0002);
		rd(12'h280, 8'h03);
		chk("irq", irq, 1'b1);
		wr(12'h281, 8'h00);
		cyc(1);
		chk("irq", irq, 1'b0);
		wr(12'h280, 8'h03);
		rd(12'h280, 8'h00);
		// Disabled, then forced levels against a high magnitude
		wr(12'h245, 8'h00);
		mag(13'h0101);
		cyc(3);
		chk("pin", pin, 1'b0);
		wr(12'h245, 8'h0D);
		cyc(2);
		chk("pin", pin, 1'b1);
		wr(12'h245, 8'h09);
		cyc(2);
		chk("pin", pin, 1'b0);
		wr(12'h245, 8'h00);
		mag(13'h0000);
		wr(12'h280, 8'h07);
		// Alignment: off, continuous, next edge
		ref_pulse();
		chk("sync", 16'(sync_cnt), 16'h0000);
		wr(12'h26F, 8'h01);
		ref_pulse();
		ref_pulse();
		chk("sync", 16'(sync_cnt), 16'h0002);
		rd(12'h26F, 8'h01);
		wr(12'h26F, 8'h03);
		ref_pulse();
		ref_pulse();
		chk("sync", 16'(sync_cnt), 16'h0003);
		rd(12'h26F, 8'h02);
		rd(12'h280, 8'h04);
		summarize();
	end
endmodule
